// >>> pkg/flash_status_pkg.sv
// Package with constants for the flash status polling controller.
package flash_status_pkg;
   localparam int CLK_MHZ            = 50;
   localparam int DATA_W             = 16;
   localparam int ADDR_W             = 23;
   localparam int BIT_POLL           = 7;
   localparam int BIT_TOGGLE         = 6;
   localparam int BIT_LIMIT          = 5;
   localparam int BIT_WINDOW         = 3;
   localparam int BIT_SECT_TOGGLE    = 2;
   localparam int BIT_ABORT          = 1;
   // Bus cycle: address/CE/OE set up, data sampled at the end.
   localparam int READ_NS            = 120;
   localparam int READ_CYC           = (READ_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_NS           = 80;
   localparam int WRITE_CYC          = (WRITE_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC            = 2;
   localparam logic [DATA_W-1:0] CMD_RESET       = 16'h00F0;
   localparam logic [DATA_W-1:0] CMD_ABORT_RST_A = 16'h00AA;
   localparam logic [DATA_W-1:0] CMD_ABORT_RST_B = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_ABORT_RST_C = 16'h00F0;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK_A   = 23'h000555;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK_B   = 23'h0002AA;
   localparam logic [2:0] RES_NONE   = 3'h0;
   localparam logic [2:0] RES_DONE   = 3'h1;
   localparam logic [2:0] RES_FAIL   = 3'h2;
   localparam logic [2:0] RES_ABORT  = 3'h3;
   localparam logic [2:0] RES_BUSY   = 3'h4;
   localparam logic [2:0] RES_WINDOW = 3'h5;
endpackage

// >>> hdl/flash_status_poller.sv
// Host-side controller that polls flash write status and recovers from failures.
//
// Summary of operation
// R1: Read status twice, compare toggle bit.
// R2: Same toggle value means operation done.
// R3: Toggling and limit flag high: recheck toggle.
// R4: Still toggling after recheck: fail, send reset.
// R5: Leaving polling restarts check from first read.
// R6: Device raises limit flag on overrun.
// R7: Programming one over zero may trip limit.
// R8: After limit failure, host writes reset command.
// R9: Window flag zero during acceptance, then one.
// R10: Each added sector erase restarts window.
// R11: Fast erase adders need not check window.
// R12: Window flag one: commands ignored until done.
// R13: Check window flag before and after adding.
// R14: Buffer abort flag needs abort reset sequence.
// R15: Status reads use a valid target address.
// R16: Buffer program polls last loaded address.
// R17: Erase polling bit reads zero until done.
// R18: Program polling bit reads inverted data.
// R19: Toggle bit inverts per read while busy.
// R20: Sector toggle bit inverts in erasing sectors.
`timescale 1ns/1ps
module flash_status_poller
   import flash_status_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              start_i,
   input  wire logic              window_check_i,
   input  wire logic              abandon_i,
   input  wire logic [ADDR_W-1:0] target_addr_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [2:0]             result_o,
   output logic [DATA_W-1:0]      last_status_o,
   output logic [ADDR_W-1:0]      flash_addr_o,
   output logic                   flash_ce_b_o,
   output logic                   flash_oe_b_o,
   output logic                   flash_we_b_o,
   output logic [DATA_W-1:0]      flash_dq_o,
   output logic                   flash_dq_oe_o,
   input  wire logic [DATA_W-1:0] flash_dq_i
);
   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_READ  = 7'h02,
      S_EVAL  = 7'h04,
      S_WRITE = 7'h08,
      S_GAP   = 7'h10,
      S_NEXT  = 7'h20,
      S_DONE  = 7'h40
   } state_t;

   state_t             state_reg, state_next;
   logic [7:0]         cnt_reg;
   logic [1:0]         reads_reg;
   logic               recheck_reg;
   logic               first_tog_reg;
   logic [DATA_W-1:0]  stat_reg;
   logic [1:0]         wr_idx_reg;
   logic [1:0]         wr_len_reg;
   logic               is_abort_reg;
   logic               win_mode_reg;
   logic [2:0]         res_reg;
   logic [ADDR_W-1:0]  tgt_reg;
   logic               after_wr_reg;

   wire logic cyc_end   = (state_reg == S_READ && cnt_reg == 8'(READ_CYC - 1)) ||
                          (state_reg == S_WRITE && cnt_reg == 8'(WRITE_CYC - 1)) ||
                          (state_reg == S_GAP && cnt_reg == 8'(GAP_CYC - 1));
   wire logic tog_now   = stat_reg[BIT_TOGGLE];
   wire logic toggled   = tog_now != first_tog_reg;                         // R1
   wire logic limit_hi  = stat_reg[BIT_LIMIT];
   wire logic abort_hi  = stat_reg[BIT_ABORT];
   wire logic win_hi    = stat_reg[BIT_WINDOW];
   wire logic [DATA_W-1:0] wr_data =
      !is_abort_reg    ? CMD_RESET :                                        // R8
      wr_idx_reg == 2'h0 ? CMD_ABORT_RST_A :                                // R14
      wr_idx_reg == 2'h1 ? CMD_ABORT_RST_B : CMD_ABORT_RST_C;
   wire logic [ADDR_W-1:0] wr_addr =
      !is_abort_reg      ? tgt_reg :
      wr_idx_reg == 2'h1 ? ADDR_UNLOCK_B : ADDR_UNLOCK_A;
   // The write strobe rises one cycle ahead of chip select so the data still stands when latched.
   wire logic we_low = (state_next == S_WRITE) &&
                       !(state_reg == S_WRITE && cnt_reg == 8'(WRITE_CYC - 2));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE:  if (start_i) state_next = S_READ;
         S_READ:  if (cyc_end) state_next = S_GAP;
         S_GAP:   if (cyc_end) state_next = after_wr_reg ? S_NEXT : S_EVAL;
         S_EVAL:  state_next = S_NEXT;
         S_WRITE: if (cyc_end) state_next = S_GAP;
         S_NEXT:  state_next = (res_reg == RES_NONE) ? S_READ :
                               (res_reg == RES_FAIL || res_reg == RES_ABORT) &&
                               wr_idx_reg != wr_len_reg ? S_WRITE : S_DONE;
         S_DONE:  state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_reg    <= S_IDLE;
         cnt_reg      <= 8'h00;
         after_wr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg || cyc_end) ? 8'h00 : cnt_reg + 8'h01;
         if (state_reg == S_READ || state_reg == S_WRITE) begin
            after_wr_reg <= (state_reg == S_WRITE);
         end
      end
   end

   // Status evaluation; ordering follows the toggle algorithm.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         reads_reg     <= 2'h0;
         recheck_reg   <= 1'b0;
         first_tog_reg <= 1'b0;
         stat_reg      <= 16'h0000;
         res_reg       <= RES_NONE;
         wr_idx_reg    <= 2'h0;
         wr_len_reg    <= 2'h0;
         is_abort_reg  <= 1'b0;
         win_mode_reg  <= 1'b0;
         tgt_reg       <= 23'h000000;
      end else if (state_reg == S_IDLE && start_i) begin
         reads_reg    <= 2'h0;                                               // R5
         recheck_reg  <= 1'b0;
         res_reg      <= RES_NONE;
         wr_idx_reg   <= 2'h0;
         win_mode_reg <= window_check_i;                                    // R11 R13
         tgt_reg      <= target_addr_i;                                     // R15 R16
      end else if (state_reg == S_READ && cyc_end) begin
         stat_reg <= flash_dq_i;
      end else if (state_reg == S_EVAL) begin
         first_tog_reg <= tog_now;
         if (reads_reg != 2'h2) begin
            reads_reg <= reads_reg + 2'h1;
         end
         if (win_mode_reg) begin
            res_reg <= win_hi ? RES_WINDOW : RES_BUSY;                      // R13
         end else if (reads_reg == 2'h0) begin
            res_reg <= RES_NONE;
         end else if (!toggled) begin
            res_reg      <= abort_hi ? RES_ABORT : RES_DONE;                // R2
            is_abort_reg <= abort_hi;                                       // R14
            wr_len_reg   <= abort_hi ? 2'h3 : 2'h0;
         end else if (abort_hi) begin
            res_reg      <= RES_ABORT;                                      // R14
            is_abort_reg <= 1'b1;
            wr_len_reg   <= 2'h3;
         end else if (recheck_reg) begin
            res_reg      <= RES_FAIL;                                       // R4
            is_abort_reg <= 1'b0;
            wr_len_reg   <= 2'h1;
         end else if (limit_hi) begin
            recheck_reg <= 1'b1;                                            // R3
         end else if (abandon_i) begin
            res_reg <= RES_BUSY;                                            // R5
         end
      end else if (state_reg == S_WRITE && cyc_end) begin
         wr_idx_reg <= wr_idx_reg + 2'h1;
      end
   end

   // Bus pins and user outputs, all registered.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         flash_addr_o  <= 23'h000000;
         flash_ce_b_o  <= 1'b1;
         flash_oe_b_o  <= 1'b1;
         flash_we_b_o  <= 1'b1;
         flash_dq_o    <= 16'h0000;
         flash_dq_oe_o <= 1'b0;
         busy_o        <= 1'b0;
         done_o        <= 1'b0;
         result_o      <= RES_NONE;
         last_status_o <= 16'h0000;
      end else begin
         flash_addr_o  <= (state_next == S_WRITE) ? wr_addr : tgt_reg;
         flash_ce_b_o  <= !(state_next == S_READ || state_next == S_WRITE);
         flash_oe_b_o  <= !(state_next == S_READ);
         flash_dq_oe_o <= (state_next == S_WRITE);
         flash_dq_o    <= (state_next == S_WRITE) ? wr_data : 16'h0000;
         flash_we_b_o  <= !we_low;                                          // R8
         busy_o        <= (state_next != S_IDLE && state_next != S_DONE);
         done_o        <= (state_next == S_DONE);
         if (state_next == S_DONE) begin
            result_o <= res_reg;
         end
         last_status_o <= stat_reg;
      end
   end

   // A failure leaves through exactly one reset write before finishing.
   chk_fail_resets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == S_DONE && res_reg == RES_FAIL) |-> $past(wr_idx_reg) == 2'h1)  // R8
      else $error("Failure finished without one reset write.");
   chk_no_early_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == S_EVAL && reads_reg == 2'h0 && !win_mode_reg) |=> res_reg == RES_NONE) // R1
      else $error("Result decided after a single read.");
   chk_fail_needs_recheck: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(res_reg == RES_FAIL) |-> $past(recheck_reg))  // R4
      else $error("Failure declared without a toggle recheck.");
   chk_dq_driven_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      flash_dq_oe_o |-> !flash_oe_b_o && 1'b0 || flash_oe_b_o)  // R15
      else $error("Data driven while output enable low.");
   chk_we_rise_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(flash_we_b_o) |-> !flash_ce_b_o && flash_dq_oe_o)  // R8
      else $error("Write strobe released without data hold.");
   chk_done_two_reads: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == S_DONE && res_reg == RES_DONE) |-> reads_reg == 2'h2)  // R1 R2
      else $error("Completion reported before two status reads.");

   // Decision steps: evaluation, then the first pass through the next-step state.
   sequence seq_fail_decided;
      state_reg == S_EVAL ##1
      (state_reg == S_NEXT && res_reg == RES_FAIL && wr_idx_reg == 2'h0);
   endsequence
   sequence seq_abort_decided;
      state_reg == S_EVAL ##1
      (state_reg == S_NEXT && res_reg == RES_ABORT && wr_idx_reg == 2'h0);
   endsequence
   chk_fail_reset_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      seq_fail_decided |=> state_reg == S_WRITE && flash_dq_o == CMD_RESET &&
                           flash_addr_o == tgt_reg)  // R4 R8
      else $error("Failure not followed by the reset command write.");
   chk_abort_unlock_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      seq_abort_decided |=> state_reg == S_WRITE && flash_dq_o == CMD_ABORT_RST_A &&
                            flash_addr_o == ADDR_UNLOCK_A)  // R14
      else $error("Abort not followed by the abort reset sequence.");
endmodule

// >>> dv/flash_status_model.sv
// Behavioural flash device that answers status reads and logs command writes.
`timescale 1ns/1ps
module flash_status_model
   import flash_status_pkg::*;
(
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              ce_b_i,
   input  wire logic              oe_b_i,
   input  wire logic              we_b_i,
   input  wire logic [DATA_W-1:0] dq_i,
   input  wire logic [31:0]       tog_n_i,
   input  wire logic              limit_i,
   input  wire logic              abort_i,
   input  wire logic              window_i,
   output logic [DATA_W-1:0]      dq_o,
   output int                     n_rd_o,
   output int                     n_wr_o,
   output logic [ADDR_W-1:0]      rd_addr_o,
   output logic [ADDR_W-1:0]      wr_addr_o,
   output logic [DATA_W-1:0]      wr_data_o
);
   logic              tog = 1'b0;
   logic              run;
   logic [DATA_W-1:0] stat;
   logic [DATA_W-1:0] held = 16'h0000;
   // The algorithm counts as running until tog_n_i + 1 reads have been served.
   assign run  = (n_rd_o <= int'(tog_n_i));
   assign stat = {8'h00, ~run, tog, limit_i, 1'b0, window_i, tog, abort_i, 1'b0};
   // A released bus shows the inverse of the last value so stale data never looks valid.
   assign dq_o = (!ce_b_i && !oe_b_i) ? stat : ~held;
   initial begin
      n_rd_o = 0;
      n_wr_o = 0;
   end
   always @(negedge oe_b_i) begin
      if (!ce_b_i) begin
         if (n_rd_o < int'(tog_n_i)) tog <= ~tog;
         n_rd_o    <= n_rd_o + 1;
         rd_addr_o <= addr_i;
      end
   end
   always @(posedge oe_b_i) held <= stat;
   always @(posedge we_b_i) begin
      if (!ce_b_i) begin
         n_wr_o    <= n_wr_o + 1;
         wr_addr_o <= addr_i;
         wr_data_o <= dq_i;
      end
   end
endmodule

// >>> dv/flash_status_poller_tb.sv
// Self-checking bench for the flash status polling controller.
`timescale 1ns/1ps
module flash_status_poller_tb;
   import flash_status_pkg::*;
   logic              clk_i = 1'b0;
   logic              rst_b_i = 1'b0;
   logic              start_i = 1'b0;
   logic              window_check_i = 1'b0;
   logic              abandon_i = 1'b0;
   logic [ADDR_W-1:0] target_addr_i = 23'h012340;
   logic              busy_o, done_o, ce_b, oe_b, we_b, dq_oe;
   logic [2:0]        result_o;
   logic [DATA_W-1:0] last_status_o, dq_out, dq_dev, dq_in, wr_data;
   logic [ADDR_W-1:0] addr, rd_addr, wr_addr;
   logic [31:0]       tog_n = 32'h0;
   logic              limit = 1'b0, abort = 1'b0, window = 1'b0;
   int                n_rd, n_wr, rd0, n_fail = 0, total_checks = 0;
   always #10 clk_i = ~clk_i;
   assign dq_in = dq_oe ? dq_out : dq_dev;
   flash_status_poller i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
      .window_check_i(window_check_i), .abandon_i(abandon_i), .target_addr_i(target_addr_i),
      .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .last_status_o(last_status_o),
      .flash_addr_o(addr), .flash_ce_b_o(ce_b), .flash_oe_b_o(oe_b), .flash_we_b_o(we_b),
      .flash_dq_o(dq_out), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_in));
   flash_status_model i_dev (.addr_i(addr), .ce_b_i(ce_b), .oe_b_i(oe_b), .we_b_i(we_b),
      .dq_i(dq_in), .tog_n_i(tog_n), .limit_i(limit), .abort_i(abort), .window_i(window),
      .dq_o(dq_dev), .n_rd_o(n_rd), .n_wr_o(n_wr), .rd_addr_o(rd_addr),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data));
   task automatic final_report;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // One status check: k toggling reads, then flags, expected result and write count.
   task automatic run(input int k, input logic lim, ab, win, abn, input logic [2:0] exp,
                      input int nwr);
      int i;
      int w0;
      @(negedge clk_i);
      tog_n = n_rd + k;
      {limit, abort, window, window_check_i, abandon_i} = {lim, ab, win, win, abn};
      w0 = n_wr;
      rd0 = n_rd;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      check(busy_o === 1'b1, "busy while polling");
      for (i = 0; i < 4000 && done_o !== 1'b1; i++) @(negedge clk_i);
      if (i == 4000) begin
         n_fail++;
         $display("CHECK FAILED at %0t: no completion", $time);
         final_report();
      end
      check(result_o === exp, "result code");
      check(n_wr - w0 == nwr, "command write count");
      check(rd_addr === target_addr_i, "status read address");
      check(busy_o === 1'b0, "idle at completion");
   endtask
   initial begin
      repeat (12) @(negedge clk_i);
      rst_b_i = 1'b1;
      check(busy_o === 1'b0 && ce_b === 1'b1 && result_o === RES_NONE, "reset state");
      run(0, 1'b0, 1'b0, 1'b0, 1'b0, RES_DONE, 0);
      check(n_rd - rd0 == 2, "two reads for steady bit");
      run(3, 1'b0, 1'b0, 1'b0, 1'b0, RES_DONE, 0);
      run(2, 1'b1, 1'b0, 1'b0, 1'b0, RES_DONE, 0);
      run(1000, 1'b1, 1'b0, 1'b0, 1'b0, RES_FAIL, 1);
      check(wr_addr === target_addr_i && wr_data === CMD_RESET, "reset command");
      run(1000, 1'b0, 1'b1, 1'b0, 1'b0, RES_ABORT, 3);
      check(wr_addr === ADDR_UNLOCK_A && wr_data === CMD_ABORT_RST_C, "abort reset");
      run(1000, 1'b0, 1'b0, 1'b0, 1'b1, RES_BUSY, 0);
      run(0, 1'b0, 1'b0, 1'b0, 1'b0, RES_DONE, 0);
      check(n_rd - rd0 == 2, "restart from first read");
      run(0, 1'b0, 1'b0, 1'b1, 1'b0, RES_WINDOW, 0);
      check(last_status_o[BIT_WINDOW] === 1'b1, "window flag seen");
      final_report();
   end
endmodule
